// [hw/flash_register_write_commands.sv]
// Contract
// - Write-enable command sets the enable latch, status bit 1.
// - After volatile write-enable the next register write touches volatile copies only.
// - Write-disable command clears the enable latch.
// - Write-disable is ignored while busy.
// - Clear-fail-flags resets erase error bit 5 and program error bit 6.
// - Clear-fail-flags is taken while busy; enable latch stays unchanged.
// - Clear-ECC resets detection, correction, interrupt bits, address trap and counter.
// - Clear-ECC needs no enable, is taken while busy, keeps the latch.
// - Legacy write needs a prior write-enable or volatile write-enable.
// - Legacy write erases then programs; failure sets program or erase error.
// - Addressed write needs write-enable; busy bit shows completion, bits 6:5 errors.
// - Read-only bits are never changed by addressed writes and raise no error.
// - OTP bits only move away from default; writing default back is silently ignored.
// - Changed nonvolatile bits take the write time; failure sets error, busy stays.
// - Addressed writes to lock and integrity-check registers are refused.
// - Lock-bit write needs enable, clears lock bit 0; then protection ops abort.
// - In read-password mode the lock bit forces reads into the boot sector.
// - Status stays readable during lock write; busy clears when it completes.
//
// The address map and register access over APB were chosen for this implementation.
`default_nettype none
module flash_register_write_commands
  import frw_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic csN,
  input wire logic serialInputLine,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eccCorrectEvt,
  input wire logic eccDetectEvt,
  input wire logic [31:0] eccEvtAddr,
  input wire logic protOpReq,
  output logic protOpGo,
  output logic protOpAbort,
  input wire logic [31:0] readAddrIn,
  output logic [31:0] readAddrOut
);
  // ==========================================================
  // Link receiver and operation timer
  frw_link_if link ();
  logic timerStart;
  logic [15:0] timerLen;
  logic timerDone;

  frw_spi_rx u_rx (
    .mclk(mclk),
    .reset(reset),
    .sclk(sclk),
    .csN(csN),
    .serialInputLine(serialInputLine),
    .link(link)
  );

  frw_op_timer u_timer (
    .mclk(mclk),
    .reset(reset),
    .start(timerStart),
    .length(timerLen),
    .done(timerDone)
  );

  // ==========================================================
  // State
  frw_state_e state_r;
  logic writeProgramLatch_r;
  logic volEnable_r;
  logic program_error_flag_r;
  logic erase_error_flag_r;
  logic [7:0] volStat_r;
  logic [7:0] volCfg_r;
  logic [7:0] nvStat_r;
  logic [7:0] nvCfg_r;
  logic [7:0] pendStat_r;
  logic [7:0] pendCfg_r;
  logic protectLockFlag_r;
  logic [7:0] cmd_r;
  logic [7:0] dat0_r;
  logic [7:0] dat1_r;
  logic [2:0] byteCnt_r;
  logic [4:0] eccStatusReg_r;
  logic [1:0] interruptStatusReg_r;
  logic [31:0] eccAddressTrap_r;
  logic [15:0] eccDetectCounter_r;
  logic [2:0] ctrl_r;
  logic busy;
  logic [7:0] statusOneVolatile;

  // Control bits: erase fail inject, program fail inject, read-password mode
  logic failErase;
  logic failProgram;
  logic pwdMode;
  assign failErase = ctrl_r[0];
  assign failProgram = ctrl_r[1];
  assign pwdMode = ctrl_r[2];

  assign busy = (state_r != ST_IDLE);
  // Busy, error flags and latch are live; the other bits come from the volatile copy
  always_comb begin
    statusOneVolatile = volStat_r & ~STAT_RO_MASK;
    statusOneVolatile[ST_BUSY] = busy;
    statusOneVolatile[ST_WEL] = writeProgramLatch_r;
    statusOneVolatile[ST_ERS] = erase_error_flag_r;
    statusOneVolatile[ST_PRG] = program_error_flag_r;
  end

  // ==========================================================
  // Command framing: opcode then up to two data bytes
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_r <= 8'h00;
      dat0_r <= 8'h00;
      dat1_r <= 8'h00;
      byteCnt_r <= 3'h0;
    end else if (link.frameStart) begin
      byteCnt_r <= 3'h0;
    end else if (link.byteValid) begin
      if (byteCnt_r == 3'h0) begin
        cmd_r <= link.byteData;
      end
      if (byteCnt_r == 3'h1) begin
        dat0_r <= link.byteData;
      end
      if (byteCnt_r == 3'h2) begin
        dat1_r <= link.byteData;
      end
      if (byteCnt_r != 3'h7) begin
        byteCnt_r <= byteCnt_r + 3'h1;
      end
    end
  end

  // ==========================================================
  // Decode, acted on when chip select rises
  logic exec;
  logic doWren, doWrenv, doWrdis, doClearFail, doClearEcc;
  logic legacyOk, addrOk, regWrite, volWrite, nvStart, nvSame, doLockStart;
  logic [7:0] newStat, newCfg;

  // Bit-type merge: read-only kept, OTP only sets away from default
  function automatic logic [7:0] mergeBits(input logic [7:0] old, input logic [7:0] data,
                                           input logic [7:0] roMask, input logic [7:0] otpMask);
    mergeBits = (old & roMask) | (data & ~roMask & ~otpMask) | ((old | data) & otpMask);
  endfunction

  always_comb begin
    exec = link.frameEnd && (byteCnt_r != 3'h0);
    doWren = exec && !busy && (cmd_r == OP_WRITE_ENABLE);
    doWrenv = exec && !busy && (cmd_r == OP_VOL_WRITE_ENABLE);
    doWrdis = exec && !busy && (cmd_r == OP_WRITE_DISABLE);
    doClearFail = exec && (cmd_r == OP_CLEAR_FAIL);
    doClearEcc = exec && (cmd_r == OP_CLEAR_ECC);
    // Legacy needs either enable; one or more data bytes
    legacyOk = exec && !busy && (cmd_r == OP_LEGACY_WRITE) && (byteCnt_r >= 3'h2)
               && (writeProgramLatch_r || volEnable_r);
    // Addressed needs the full latch and exactly two data bytes, address then value
    addrOk = exec && !busy && (cmd_r == OP_ADDR_WRITE) && (byteCnt_r == 3'h3)
             && writeProgramLatch_r;
    newStat = nvStat_r;
    newCfg = nvCfg_r;
    if (volEnable_r) begin
      newStat = volStat_r;
      newCfg = volCfg_r;
    end
    regWrite = 1'b0;
    if (legacyOk) begin
      regWrite = 1'b1;
      newStat = mergeBits(newStat, dat0_r, STAT_RO_MASK, 8'h00);
      if (byteCnt_r >= 3'h3) begin
        newCfg = mergeBits(newCfg, dat1_r, CFG_RO_MASK, CFG_OTP_MASK);
      end
    end else if (addrOk) begin
      // Lock and integrity registers fall through unwritten
      if (dat0_r == RA_STATUS1) begin
        regWrite = 1'b1;
        newStat = mergeBits(newStat, dat1_r, STAT_RO_MASK, 8'h00);
      end else if (dat0_r == RA_CONFIG1) begin
        regWrite = 1'b1;
        newCfg = mergeBits(newCfg, dat1_r, CFG_RO_MASK, CFG_OTP_MASK);
      end
    end
    volWrite = regWrite && volEnable_r;
    nvSame = (newStat == nvStat_r) && (newCfg == nvCfg_r);
    nvStart = regWrite && !volEnable_r && !nvSame;
    doLockStart = exec && !busy && (cmd_r == OP_LOCK_WRITE) && writeProgramLatch_r;
    timerStart = nvStart || doLockStart;
    timerLen = nvStart ? NV_WRITE_LEN : LOCK_WRITE_LEN;
  end

  // ==========================================================
  // Operation sequencer; busy stays set after a failure
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (nvStart) begin
            state_r <= ST_NV_BUSY;
          end else if (doLockStart) begin
            state_r <= ST_LOCK_BUSY;
          end
        end
        ST_NV_BUSY: begin
          if (timerDone) begin
            state_r <= (failErase || failProgram) ? ST_FAILED : ST_IDLE;
          end
        end
        ST_LOCK_BUSY: begin
          if (timerDone) begin
            state_r <= ST_IDLE;
          end
        end
        ST_FAILED: begin
          if (doClearFail) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Pending values held across the self-timed write
  always_ff @(posedge mclk) begin
    if (reset) begin
      pendStat_r <= STAT_RESET;
      pendCfg_r <= CFG_RESET;
    end else if (nvStart) begin
      pendStat_r <= newStat;
      pendCfg_r <= newCfg;
    end
  end

  // ==========================================================
  // Enable latch and volatile-only enable
  always_ff @(posedge mclk) begin
    if (reset) begin
      writeProgramLatch_r <= 1'b0;
      volEnable_r <= 1'b0;
    end else begin
      if (doWren) begin
        writeProgramLatch_r <= 1'b1;
        volEnable_r <= 1'b0;
      end else if (doWrenv) begin
        volEnable_r <= 1'b1;
      end else if (doWrdis) begin
        writeProgramLatch_r <= 1'b0;
        volEnable_r <= 1'b0;
      end else if (regWrite && (volEnable_r || nvSame)) begin
        writeProgramLatch_r <= 1'b0;
        volEnable_r <= 1'b0;
      end else if (timerDone && state_r == ST_LOCK_BUSY) begin
        writeProgramLatch_r <= 1'b0;
      end else if (timerDone && state_r == ST_NV_BUSY && !(failErase || failProgram)) begin
        writeProgramLatch_r <= 1'b0;
      end
    end
  end

  // Error flags: a failure in the clearing cycle still sets the flag
  always_ff @(posedge mclk) begin
    if (reset) begin
      program_error_flag_r <= 1'b0;
      erase_error_flag_r <= 1'b0;
    end else begin
      if (doClearFail) begin
        program_error_flag_r <= 1'b0;
        erase_error_flag_r <= 1'b0;
      end
      if (timerDone && state_r == ST_NV_BUSY) begin
        if (failErase) begin
          erase_error_flag_r <= 1'b1;
        end
        if (failProgram) begin
          program_error_flag_r <= 1'b1;
        end
      end
    end
  end

  // Register copies; nonvolatile copy only moves after a good write
  always_ff @(posedge mclk) begin
    if (reset) begin
      volStat_r <= STAT_RESET;
      volCfg_r <= CFG_RESET;
      nvStat_r <= STAT_RESET;
      nvCfg_r <= CFG_RESET;
    end else if (volWrite) begin
      volStat_r <= newStat;
      volCfg_r <= newCfg;
    end else if (timerDone && state_r == ST_NV_BUSY && !(failErase || failProgram)) begin
      nvStat_r <= pendStat_r;
      nvCfg_r <= pendCfg_r;
      volStat_r <= pendStat_r;
      volCfg_r <= pendCfg_r;
    end
  end

  // Lock flag cleared only by its own command at completion
  always_ff @(posedge mclk) begin
    if (reset) begin
      protectLockFlag_r <= LOCK_RESET;
    end else if (timerDone && state_r == ST_LOCK_BUSY) begin
      protectLockFlag_r <= 1'b0;
    end
  end

  // ==========================================================
  // ECC status: new events win over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      eccStatusReg_r <= 5'h00;
      interruptStatusReg_r <= 2'h0;
      eccAddressTrap_r <= 32'h0000_0000;
      eccDetectCounter_r <= 16'h0000;
    end else begin
      if (doClearEcc) begin
        eccStatusReg_r <= 5'h00;
        interruptStatusReg_r <= 2'h0;
        eccAddressTrap_r <= 32'h0000_0000;
        eccDetectCounter_r <= 16'h0000;
      end
      if (eccCorrectEvt) begin
        eccStatusReg_r[3] <= 1'b1;
        interruptStatusReg_r[0] <= 1'b1;
      end
      if (eccDetectEvt) begin
        eccStatusReg_r[4] <= 1'b1;
        interruptStatusReg_r[1] <= 1'b1;
        eccAddressTrap_r <= eccEvtAddr;
        eccDetectCounter_r <= (doClearEcc ? 16'h0000 : eccDetectCounter_r) + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Protection side effects of the lock bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      protOpGo <= 1'b0;
      protOpAbort <= 1'b0;
      readAddrOut <= 32'h0000_0000;
    end else begin
      protOpGo <= protOpReq && protectLockFlag_r;
      protOpAbort <= protOpReq && !protectLockFlag_r;
      readAddrOut <= readAddrIn;
      if (pwdMode && !protectLockFlag_r) begin
        // Keeps reads inside the boot sector while the lock bit is clear
        readAddrOut <= {{(32 - BOOT_SECTOR_BITS){1'b0}}, readAddrIn[BOOT_SECTOR_BITS-1:0]};
      end
    end
  end

  // ==========================================================
  // APB slave: no wait state, data latched in the setup cycle
  logic apbSetup;
  logic apbMapped;
  assign apbSetup = psel && !penable && !pready;
  assign apbMapped = (paddr == APB_STATUS) || (paddr == APB_REGS) || (paddr == APB_ECC)
                     || (paddr == APB_TRAP) || (paddr == APB_CTRL) || (paddr == APB_LOCK);

  // Status read stays live even during self-timed operations
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apbSetup;
      pslverr <= apbSetup && !apbMapped;
      if (apbSetup && !pwrite) begin
        case (paddr)
          APB_STATUS: prdata <= {24'h000000, statusOneVolatile};
          APB_REGS: prdata <= {nvCfg_r, nvStat_r, volCfg_r, volStat_r};
          APB_ECC: prdata <= {eccDetectCounter_r, 6'h00, interruptStatusReg_r, 3'h0, eccStatusReg_r};
          APB_TRAP: prdata <= eccAddressTrap_r;
          APB_CTRL: prdata <= {29'h00000000, ctrl_r};
          APB_LOCK: prdata <= {31'h00000000, protectLockFlag_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end else if (apbSetup) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Control register write at the completing edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_r <= CTRL_RESET;
    end else if (psel && penable && pready && pwrite && (paddr == APB_CTRL)) begin
      ctrl_r <= pwdata[2:0];
    end
  end
endmodule // flash_register_write_commands
`default_nettype wire

// [hw/frw_link_if.sv]
`default_nettype none
// ==========================================================
// Byte stream from the serial receiver to the command core
interface frw_link_if;
  logic frameStart;
  logic frameEnd;
  logic byteValid;
  logic [7:0] byteData;
  modport rx (output frameStart, output frameEnd, output byteValid, output byteData);
  modport core (input frameStart, input frameEnd, input byteValid, input byteData);
endinterface
`default_nettype wire

// [hw/frw_op_timer.sv]
`default_nettype none
// ==========================================================
// Countdown for the self-timed operations; done is one pulse
module frw_op_timer (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic [15:0] length,
  output logic done
);
  logic [15:0] cnt_r;
  logic run_r;

  // A fresh start reloads the count
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= 16'h0000;
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= length;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r <= 16'h0001) begin
          run_r <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end
endmodule // frw_op_timer
`default_nettype wire

// [hw/frw_pkg.sv]
`default_nettype none
// ==========================================================
// Shared constants for the register-write command block
package frw_pkg;
  // Clock and self-timed operation lengths
  localparam int CLK_PERIOD_NS = 4;
  localparam int NV_WRITE_NS = 2000;
  localparam int LOCK_WRITE_NS = 1000;
  // Least times round up to whole cycles
  localparam int NV_WRITE_CYC = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_WRITE_CYC = (LOCK_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] NV_WRITE_LEN = 16'(NV_WRITE_CYC);
  localparam logic [15:0] LOCK_WRITE_LEN = 16'(LOCK_WRITE_CYC);

  // Opcodes of the serial commands
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h11;
  localparam logic [7:0] OP_VOL_WRITE_ENABLE = 8'h12;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h13;
  localparam logic [7:0] OP_CLEAR_FAIL = 8'h14;
  localparam logic [7:0] OP_CLEAR_ECC = 8'h15;
  localparam logic [7:0] OP_LEGACY_WRITE = 8'h16;
  localparam logic [7:0] OP_ADDR_WRITE = 8'h17;
  localparam logic [7:0] OP_LOCK_WRITE = 8'h18;

  // Status register one bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_ERS = 5;
  localparam int ST_PRG = 6;

  // Device register addresses used by the addressed write
  localparam logic [7:0] RA_STATUS1 = 8'h00;
  localparam logic [7:0] RA_CONFIG1 = 8'h02;
  localparam logic [7:0] RA_LOCK = 8'h10;
  localparam logic [7:0] RA_INTEGRITY = 8'h20;

  // Bit types and reset values
  localparam logic [7:0] STAT_RO_MASK = 8'h63;
  localparam logic [7:0] CFG_RO_MASK = 8'h02;
  localparam logic [7:0] CFG_OTP_MASK = 8'h01;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic LOCK_RESET = 1'b1;
  localparam int BOOT_SECTOR_BITS = 18;

  // APB byte offsets
  localparam logic [7:0] APB_STATUS = 8'h00;
  localparam logic [7:0] APB_REGS = 8'h04;
  localparam logic [7:0] APB_ECC = 8'h08;
  localparam logic [7:0] APB_TRAP = 8'h0C;
  localparam logic [7:0] APB_CTRL = 8'h10;
  localparam logic [7:0] APB_LOCK = 8'h14;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_NV_BUSY, ST_LOCK_BUSY, ST_FAILED} frw_state_e;
endpackage
`default_nettype wire

// [hw/frw_spi_rx.sv]
`default_nettype none
// ==========================================================
// Serial receiver: samples the pins on mclk, shifts bytes MSB first
module frw_spi_rx (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic csN,
  input wire logic serialInputLine,
  frw_link_if.rx link
);
  logic [1:0] sclkSync_r;
  logic [1:0] csSync_r;
  logic [1:0] siSync_r;
  logic sclkPrev_r;
  logic csPrev_r;
  logic [2:0] bitCnt_r;
  logic [6:0] shift_r;
  logic sclkRise;

  // Two-stage synchronisers; only stage one feeds stage two
  always_ff @(posedge mclk) begin
    if (reset) begin
      sclkSync_r <= 2'h0;
      csSync_r <= 2'h3;
      siSync_r <= 2'h0;
      sclkPrev_r <= 1'b0;
      csPrev_r <= 1'b1;
    end else begin
      sclkSync_r <= {sclkSync_r[0], sclk};
      csSync_r <= {csSync_r[0], csN};
      siSync_r <= {siSync_r[0], serialInputLine};
      sclkPrev_r <= sclkSync_r[1];
      csPrev_r <= csSync_r[1];
    end
  end

  assign sclkRise = sclkSync_r[1] & ~sclkPrev_r & ~csSync_r[1];

  // Shift on rising serial clock, restart at every frame
  always_ff @(posedge mclk) begin
    if (reset) begin
      bitCnt_r <= 3'h0;
      shift_r <= 7'h00;
      link.byteValid <= 1'b0;
      link.byteData <= 8'h00;
      link.frameStart <= 1'b0;
      link.frameEnd <= 1'b0;
    end else begin
      link.frameStart <= csPrev_r & ~csSync_r[1];
      link.frameEnd <= ~csPrev_r & csSync_r[1];
      link.byteValid <= 1'b0;
      if (csSync_r[1]) begin
        bitCnt_r <= 3'h0;
      end else if (sclkRise) begin
        shift_r <= {shift_r[5:0], siSync_r[1]};
        bitCnt_r <= bitCnt_r + 3'h1;
        if (bitCnt_r == 3'h7) begin
          link.byteValid <= 1'b1;
          link.byteData <= {shift_r, siSync_r[1]};
        end
      end
    end
  end
endmodule // frw_spi_rx
`default_nettype wire

// [verification/flash_register_write_commands_bench.sv]
`default_nettype none
// ==========================================================
// Self-checking bench for the register-write command block
module flash_register_write_commands_bench
  import frw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
  logic eccCorrectEvt = 1'h0, eccDetectEvt = 1'h0, protOpReq = 1'h0, protOpGo, protOpAbort;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, eccEvtAddr = 32'h0, readAddrIn = 32'h0, prdata, readAddrOut, rd;
  wire logic sclk, csN, serialInputLine;
  int error_cnt = 0, n_compared = 0;
`define CK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; $display("ERROR %0t got %h", $time, a); end end
  always #2 mclk = ~mclk;
  frw_spi_host u_host (.sclk, .csN, .serialInputLine);
  flash_register_write_commands u_dut (.mclk, .reset, .sclk, .csN, .serialInputLine, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .eccCorrectEvt, .eccDetectEvt, .eccEvtAddr, .protOpReq,
    .protOpGo, .protOpAbort, .readAddrIn, .readAddrOut);
  // ==========================================================
  // Bus and link helpers; a hung slave counts as an error
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      error_cnt++;
      $display("ERROR %0t no pready", $time);
    end
  endtask
  task automatic rs(input logic [7:0] a); apb(1'h0, a, 32'h0); endtask
  // Realign to a clock edge so later drives never race the frame's end
  task automatic sd(input logic [23:0] d, input int n);
    u_host.send(d, n);
    @(posedge mclk);
  endtask
  task automatic idle;
    int k;
    k = 0;
    do begin
      rs(APB_STATUS);
      k++;
    end while (rd[ST_BUSY] !== 1'h0 && k < 400);
    if (rd[ST_BUSY] !== 1'h0) begin
      error_cnt++;
      $display("ERROR %0t still busy", $time);
    end
  endtask
  // Answer is looked at mid-cycle, while it stands
  task automatic prot(input logic go);
    @(posedge mclk);
    protOpReq <= 1'h1;
    @(posedge mclk);
    protOpReq <= 1'h0;
    @(negedge mclk);
    `CK({protOpGo, protOpAbort}, {go, ~go})
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_latch;
    rs(8'h18);
    `CK({er, rd}, {1'h1, 32'h0})
    sd(24'(OP_WRITE_ENABLE), 1);
    rs(APB_STATUS);
    `CK(rd[ST_WEL], 1'h1)
    sd(24'(OP_WRITE_DISABLE), 1);
    rs(APB_STATUS);
    `CK(rd[ST_WEL], 1'h0)
    sd({OP_ADDR_WRITE, RA_STATUS1, 8'h04}, 3);
    sd(24'(OP_LOCK_WRITE), 1);
    rs(APB_REGS);
    `CK(rd, 32'h0)
    rs(APB_LOCK);
    `CK(rd[0], 1'h1)
    $display("t_latch done");
  endtask
  task automatic t_nv;
    sd(24'(OP_VOL_WRITE_ENABLE), 1);
    sd({8'h00, OP_LEGACY_WRITE, 8'h04}, 2);
    rs(APB_REGS);
    `CK(rd, 32'h00000004)
    sd(24'(OP_WRITE_ENABLE), 1);
    sd({OP_ADDR_WRITE, RA_STATUS1, 8'hFF}, 3);
    rs(APB_STATUS);
    `CK({rd[ST_BUSY], rd[ST_WEL]}, 2'h3)
    sd(24'(OP_WRITE_DISABLE), 1);
    rs(APB_STATUS);
    `CK(rd[ST_WEL], 1'h1)
    idle;
    `CK(rd[6:5], 2'h0)
    rs(APB_REGS);
    `CK(rd[23:16], 8'h9C)
    $display("t_nv done");
  endtask
  task automatic t_fail;
    apb(1'h1, APB_CTRL, 32'h3);
    sd(24'(OP_WRITE_ENABLE), 1);
    sd({OP_LEGACY_WRITE, 8'h9C, 8'h01}, 3);
    repeat (NV_WRITE_CYC + 20) @(posedge mclk);
    rs(APB_STATUS);
    `CK({rd[ST_PRG], rd[ST_ERS], rd[ST_BUSY], rd[ST_WEL]}, 4'hF)
    sd(24'(OP_CLEAR_FAIL), 1);
    rs(APB_STATUS);
    `CK({rd[ST_PRG], rd[ST_ERS], rd[ST_BUSY], rd[ST_WEL]}, 4'h1)
    apb(1'h1, APB_CTRL, 32'h0);
    sd(24'(OP_WRITE_ENABLE), 1);
    sd({OP_ADDR_WRITE, RA_CONFIG1, 8'h01}, 3);
    idle;
    sd(24'(OP_WRITE_ENABLE), 1);
    sd({OP_ADDR_WRITE, RA_CONFIG1, 8'h00}, 3);
    idle;
    `CK(rd[6:5], 2'h0)
    rs(APB_REGS);
    `CK(rd[31:24], 8'h01)
    $display("t_fail done");
  endtask
  task automatic t_lock;
    readAddrIn <= 32'hFFFFFFFF;
    sd(24'(OP_WRITE_ENABLE), 1);
    sd({OP_ADDR_WRITE, RA_LOCK, 8'h00}, 3);
    sd({OP_ADDR_WRITE, RA_INTEGRITY, 8'h55}, 3);
    rs(APB_LOCK);
    `CK(rd[0], 1'h1)
    prot(1'h1);
    sd(24'(OP_WRITE_ENABLE), 1);
    sd(24'(OP_LOCK_WRITE), 1);
    rs(APB_STATUS);
    `CK(rd[ST_BUSY], 1'h1)
    idle;
    `CK(rd[ST_BUSY], 1'h0)
    rs(APB_LOCK);
    `CK(rd[0], 1'h0)
    prot(1'h0);
    `CK(readAddrOut, 32'hFFFFFFFF)
    apb(1'h1, APB_CTRL, 32'h4);
    repeat (2) @(posedge mclk);
    `CK(readAddrOut, 32'h0003FFFF)
    $display("t_lock done");
  endtask
  task automatic t_ecc;
    sd(24'(OP_WRITE_ENABLE), 1);
    eccDetectEvt <= 1'h1;
    eccCorrectEvt <= 1'h1;
    eccEvtAddr <= 32'h0000ABC0;
    @(posedge mclk);
    eccDetectEvt <= 1'h0;
    eccCorrectEvt <= 1'h0;
    rs(APB_TRAP);
    `CK(rd, 32'h0000ABC0)
    rs(APB_ECC);
    `CK(rd, 32'h00010318)
    sd(24'(OP_CLEAR_ECC), 1);
    rs(APB_ECC);
    `CK(rd, 32'h0)
    rs(APB_TRAP);
    `CK(rd, 32'h0)
    rs(APB_STATUS);
    `CK(rd[ST_WEL], 1'h1)
    $display("t_ecc done");
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'h0;
    repeat (4) @(posedge mclk);
    t_latch;
    t_nv;
    t_fail;
    t_lock;
    t_ecc;
    end_of_test;
  end
  // Watchdog: the tests need some 20 us, so 200 us means a hang
  initial begin
    #200000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test;
  end
`undef CK
endmodule // flash_register_write_commands_bench
`default_nettype wire

// [verification/frw_asserts.sv]
`default_nettype none
// ==========================================================
// Port checks: APB answer timing, protection and address outputs
module frw_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic protOpReq,
  input wire logic protOpGo,
  input wire logic protOpAbort,
  input wire logic [31:0] readAddrIn,
  input wire logic [31:0] readAddrOut
);
  logic [31:0] prevAddr_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Previous read address, for the registered copy
  always_ff @(posedge mclk) prevAddr_r <= readAddrIn;
  a_setup_ready: assert property (psel && !penable |=> pready) else $error("setup not answered");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_idle_quiet: assert property (!psel |=> !pready && !pslverr) else $error("answer without request");
  a_err_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("bad error read");
  a_prot_answer: assert property (protOpReq |=> protOpGo != protOpAbort)
    else $error("protection request unanswered");
  a_prot_cause: assert property (protOpGo || protOpAbort |-> $past(protOpReq))
    else $error("protection answer without request");
  a_addr_low: assert property (!$past(reset) |-> readAddrOut[17:0] == prevAddr_r[17:0])
    else $error("low address bits altered");
  a_addr_high: assert property (readAddrOut[31:18] != 14'h0 |-> readAddrOut == prevAddr_r)
    else $error("high address bits corrupted");
endmodule // frw_asserts
bind flash_register_write_commands frw_asserts u_chk (.mclk, .reset, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .protOpReq, .protOpGo, .protOpAbort, .readAddrIn, .readAddrOut);
`default_nettype wire

// [verification/frw_spi_host.sv]
`default_nettype none
// ==========================================================
// Host model: mode 0, MSB first, clock still between frames
module frw_spi_host (
  output logic sclk,
  output logic csN,
  output logic serialInputLine
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'h0;
    csN = 1'h1;
    serialInputLine = 1'h0;
  end
  // Opcode then data bytes on the one input line
  task automatic send(input logic [23:0] d, input int nb);
    csN = 1'h0;
    for (int i = nb * 8 - 1; i >= 0; i--) begin
      serialInputLine = d[i];
      #16 sclk = 1'h1;
      #16 sclk = 1'h0;
    end
    #16 csN = 1'h1;
    // Released line shows the inverse, never a held value
    serialInputLine = ~serialInputLine;
    #80;
  endtask
endmodule // frw_spi_host
`default_nettype wire
